// ==== src/dps_pkg.sv ====
// constants shared by the drive protection supervisor
// assumes a 250 MHz system clock and an APB register port
// Operation
// - overload stop response: latch overload fault
// - overload continue response: alarm while overloaded
// - voltage regulation: 0 enables, 1 disables
// - input phase loss trips output and contact
// - input loss ignored below 30% current
// - output phase loss trips output and contact
// - output loss ignored below 10% current
// - over-torque select: off, at-speed, running
// - over-torque: above level for set time
// - over-torque action: decel, alarm, coast
// - low-torque select: off, at-speed, running
// - low-torque: below level for set time
// - low-torque action: decel, alarm, coast
// - scaling: current in V/f, torque in vector
// - relay shows torque detection at code 12/25
// - earth leakage over 50%: coast and contact
// - external fault action: decel, coast, continue
// - external fault watched always or when running
package dps_pkg;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] CFG_OFS = 8'h00;
  localparam logic [7:0] OVT_OFS = 8'h04;
  localparam logic [7:0] LOWT_OFS = 8'h08;
  localparam logic [7:0] RELAY_OFS = 8'h0C;
  localparam logic [7:0] STAT_OFS = 8'h10;
  localparam logic [7:0] CTRL_OFS = 8'h14;
  // cfg fields
  localparam int CFG_OL_CONT = 0;
  localparam int CFG_AVR_DIS = 1;
  localparam int CFG_IPL_EN = 2;
  localparam int CFG_OPL_EN = 3;
  localparam int CFG_GF_EN = 4;
  localparam int CFG_EXT_RUN = 5;
  localparam int CFG_EXT_ACT_LSB = 6;
  localparam int CFG_MODE_LSB = 8;
  localparam logic [9:0] CFG_RST = 10'h000;
  // torque register fields
  localparam int TQ_SEL_LSB = 0;
  localparam int TQ_ACT_LSB = 2;
  localparam int TQ_LVL_LSB = 4;
  localparam int TQ_TIME_LSB = 16;
  localparam logic [22:0] TQ_RST = 23'h000000;
  // relay function fields
  localparam int RLY2_LSB = 8;
  localparam logic [12:0] RELAY_RST = 13'h0000;
  localparam logic [4:0] RLY_FN_TQ_A = 5'h0C;
  localparam logic [4:0] RLY_FN_TQ_B = 5'h19;
  localparam int CTRL_CLR = 0;
  // fault vector bit positions
  localparam int F_OL = 0;
  localparam int F_IPL = 1;
  localparam int F_OPL = 2;
  localparam int F_GF = 3;
  localparam int F_OVT = 4;
  localparam int F_LOWT = 5;
  localparam int F_EXT = 6;
  localparam int NFAULT = 7;
  localparam int STAT_ALM_LSB = 8;
  localparam int STAT_DET_LSB = 12;
  // ----------------------------------------------------------------
  // codes and thresholds
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {DPS_SEL_OFF = 2'b00, DPS_SEL_ATSPD = 2'b01, DPS_SEL_RUN = 2'b10} dps_sel_t;
  typedef enum logic [1:0] {DPS_ACT_DECEL = 2'b00, DPS_ACT_ALARM = 2'b01, DPS_ACT_COAST = 2'b10} dps_act_t;
  typedef enum logic [1:0] {DPS_EXT_DECEL = 2'b00, DPS_EXT_COAST = 2'b01, DPS_EXT_CONT = 2'b10} dps_ext_t;
  typedef enum logic [1:0] {DPS_VF = 2'b00, DPS_VF_ENC = 2'b01, DPS_SLV = 2'b10, DPS_SV = 2'b11} dps_mode_t;
  localparam logic [9:0] IPL_MIN_PCT = 10'h01E;
  localparam logic [9:0] OPL_MIN_PCT = 10'h00A;
  localparam logic [9:0] GF_LIM_PCT = 10'h032;
  // ----------------------------------------------------------------
  // timing: one time step is 0.1 s
  // ----------------------------------------------------------------
  localparam int TICK_MS = 100;
  localparam int CLK_MHZ = 250;
  localparam int TICK_CYC_DEF = TICK_MS * 1000 * CLK_MHZ;
  localparam logic [6:0] TIME_MAX = 7'h64;
endpackage

// ==== src/dps_sync.sv ====
// two-flop synchroniser for asynchronous pin levels
// assumes inputs are slow levels, not pulses
`timescale 1ns/1ns
module dps_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] q_reg;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_reg <= '0;
      q_reg <= '0;
    end else begin
      meta_reg <= d_i;
      q_reg <= meta_reg;
    end
  end
  assign q_o = q_reg;
endmodule // dps_sync

// ==== src/dps_top.sv ====
// drive protection supervisor: fault latching, stop action, relays
// assumes measurements come from logic on clk_i; fault pins are async
`timescale 1ns/1ns
module dps_top #(
  parameter int TICK_CYC = dps_pkg::TICK_CYC_DEF
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // drive state and measurements, same clock
  input wire logic running_i,
  input wire logic at_set_freq_i,
  input wire logic motor_overload_condition_i,
  input wire logic [9:0] out_current_pct_i,
  input wire logic [9:0] motor_torque_pct_i,
  input wire logic [9:0] leakage_pct_i,
  // asynchronous pins
  input wire logic in_phase_loss_i,
  input wire logic out_phase_loss_i,
  input wire logic ext_fault_i,
  input wire logic fault_reset_i,
  // stop control and outputs
  output logic coast_stop_o,
  output logic decel_stop_o,
  output logic fault_contact_o,
  output logic output_voltage_regulation_o,
  output logic relay_output_one_o,
  output logic relay_output_two_o
);
  // ----------------------------------------------------------------
  // pin synchronisation
  // ----------------------------------------------------------------
  logic [3:0] pins_s;
  dps_sync #(.W(4)) u_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .d_i({fault_reset_i, ext_fault_i, out_phase_loss_i, in_phase_loss_i}),
    .q_o(pins_s)
  );
  wire ipl_s = pins_s[0];
  wire opl_s = pins_s[1];
  wire ext_s = pins_s[2];
  wire rst_req_s = pins_s[3];

  // ----------------------------------------------------------------
  // apb registers
  // ----------------------------------------------------------------
  localparam int NFAULT_W = dps_pkg::NFAULT;
  logic [9:0] cfg_reg;
  logic [22:0] ovt_reg;
  logic [22:0] lowt_reg;
  logic [12:0] relay_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic rst_req_d_reg;
  logic [NFAULT_W-1:0] fault_reg;
  logic [3:0] alarm_reg;
  logic coast_reg;
  logic decel_reg;
  logic contact_reg;
  logic avr_reg;
  logic rly1_reg;
  logic rly2_reg;

  // one wait state so read data can leave a flop
  wire acc = psel_i & penable_i;
  wire acc_done = acc & pready_reg;
  wire wr_en = acc_done & pwrite_i;
  wire sel_cfg = (paddr_i == dps_pkg::CFG_OFS);
  wire sel_ovt = (paddr_i == dps_pkg::OVT_OFS);
  wire sel_lowt = (paddr_i == dps_pkg::LOWT_OFS);
  wire sel_relay = (paddr_i == dps_pkg::RELAY_OFS);
  wire sel_stat = (paddr_i == dps_pkg::STAT_OFS);
  wire sel_ctrl = (paddr_i == dps_pkg::CTRL_OFS);
  wire mapped = sel_cfg | sel_ovt | sel_lowt | sel_relay | sel_stat | sel_ctrl;
  wire sw_clr = wr_en & sel_ctrl & pwdata_i[dps_pkg::CTRL_CLR];

  wire [9:0] cfg_next = (wr_en && sel_cfg) ? pwdata_i[9:0] : cfg_reg;
  wire [22:0] ovt_next = (wr_en && sel_ovt) ? pwdata_i[22:0] : ovt_reg;
  wire [22:0] lowt_next = (wr_en && sel_lowt) ? pwdata_i[22:0] : lowt_reg;
  wire [12:0] relay_next = (wr_en && sel_relay) ? pwdata_i[12:0] : relay_reg;

  // ----------------------------------------------------------------
  // configuration fields
  // ----------------------------------------------------------------
  wire ol_cont = cfg_reg[dps_pkg::CFG_OL_CONT];
  wire ipl_en = cfg_reg[dps_pkg::CFG_IPL_EN];
  wire opl_en = cfg_reg[dps_pkg::CFG_OPL_EN];
  wire gf_en = cfg_reg[dps_pkg::CFG_GF_EN];
  wire ext_run_only = cfg_reg[dps_pkg::CFG_EXT_RUN];
  wire [1:0] ext_act = cfg_reg[dps_pkg::CFG_EXT_ACT_LSB +: 2];
  wire [1:0] ctrl_mode = cfg_reg[dps_pkg::CFG_MODE_LSB +: 2];
  wire [1:0] ovt_sel = ovt_reg[dps_pkg::TQ_SEL_LSB +: 2];
  wire [1:0] ovt_act = ovt_reg[dps_pkg::TQ_ACT_LSB +: 2];
  wire [1:0] lowt_sel = lowt_reg[dps_pkg::TQ_SEL_LSB +: 2];
  wire [1:0] lowt_act = lowt_reg[dps_pkg::TQ_ACT_LSB +: 2];

  // arming per select code: off, at set frequency, whole run
  function automatic logic arm_of(input logic [1:0] sel, input logic run, input logic at_spd);
    arm_of = (sel == dps_pkg::DPS_SEL_RUN) ? run :
             ((sel == dps_pkg::DPS_SEL_ATSPD) ? (run & at_spd) : 1'b0);
  endfunction

  function automatic logic fn_is_torque(input logic [4:0] fn);
    fn_is_torque = (fn == dps_pkg::RLY_FN_TQ_A) || (fn == dps_pkg::RLY_FN_TQ_B);
  endfunction

  // ----------------------------------------------------------------
  // torque detection
  // ----------------------------------------------------------------
  // vector modes compare motor torque, v/f modes output current
  wire vector_mode = (ctrl_mode == dps_pkg::DPS_SLV) || (ctrl_mode == dps_pkg::DPS_SV);
  wire [9:0] tq_value = vector_mode ? motor_torque_pct_i : out_current_pct_i;
  wire ovt_arm = arm_of(ovt_sel, running_i, at_set_freq_i);
  wire lowt_arm = arm_of(lowt_sel, running_i, at_set_freq_i);
  logic ovt_det;
  logic lowt_det;

  dps_torque_det #(.OVER(1'b1), .TICK_CYC(TICK_CYC)) u_ovt (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .arm_i(ovt_arm),
    .value_i(tq_value),
    .level_i(ovt_reg[dps_pkg::TQ_LVL_LSB +: 9]),
    .time_i(ovt_reg[dps_pkg::TQ_TIME_LSB +: 7]),
    .detect_o(ovt_det)
  );

  dps_torque_det #(.OVER(1'b0), .TICK_CYC(TICK_CYC)) u_lowt (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .arm_i(lowt_arm),
    .value_i(tq_value),
    .level_i(lowt_reg[dps_pkg::TQ_LVL_LSB +: 9]),
    .time_i(lowt_reg[dps_pkg::TQ_TIME_LSB +: 7]),
    .detect_o(lowt_det)
  );

  // ----------------------------------------------------------------
  // fault and alarm sources
  // ----------------------------------------------------------------
  wire ext_watch = !ext_run_only || running_i;
  wire ext_active = ext_s & ext_watch;
  logic [NFAULT_W-1:0] fault_set;
  assign fault_set[dps_pkg::F_OL] = motor_overload_condition_i & ~ol_cont;
  assign fault_set[dps_pkg::F_IPL] = ipl_en & ipl_s & (out_current_pct_i >= dps_pkg::IPL_MIN_PCT);
  assign fault_set[dps_pkg::F_OPL] = opl_en & opl_s & (out_current_pct_i >= dps_pkg::OPL_MIN_PCT);
  assign fault_set[dps_pkg::F_GF] = gf_en & (leakage_pct_i > dps_pkg::GF_LIM_PCT);
  assign fault_set[dps_pkg::F_OVT] = ovt_det & (ovt_act != dps_pkg::DPS_ACT_ALARM);
  assign fault_set[dps_pkg::F_LOWT] = lowt_det & (lowt_act != dps_pkg::DPS_ACT_ALARM);
  assign fault_set[dps_pkg::F_EXT] = ext_active & (ext_act != dps_pkg::DPS_EXT_CONT);

  // reset request acts on its rising edge only, so a held input cannot mask a new trip
  wire fault_clr = (rst_req_s & ~rst_req_d_reg) | sw_clr;
  // a trip in the clearing cycle wins
  wire [NFAULT_W-1:0] fault_next = fault_set | (fault_reg & ~{NFAULT_W{fault_clr}});

  // which latched faults coast; the rest decelerate
  logic [NFAULT_W-1:0] coast_mask;
  assign coast_mask[dps_pkg::F_OL] = 1'b1;
  assign coast_mask[dps_pkg::F_IPL] = 1'b1;
  assign coast_mask[dps_pkg::F_OPL] = 1'b1;
  assign coast_mask[dps_pkg::F_GF] = 1'b1;
  assign coast_mask[dps_pkg::F_OVT] = (ovt_act == dps_pkg::DPS_ACT_COAST);
  assign coast_mask[dps_pkg::F_LOWT] = (lowt_act == dps_pkg::DPS_ACT_COAST);
  assign coast_mask[dps_pkg::F_EXT] = (ext_act == dps_pkg::DPS_EXT_COAST);
  wire coast_next = |(fault_next & coast_mask);
  wire decel_next = |(fault_next & ~coast_mask) & ~coast_next;
  wire contact_next = |fault_next;

  // alarms follow their condition and need no reset
  wire [3:0] alarm_next = {ext_active & (ext_act == dps_pkg::DPS_EXT_CONT),
                           lowt_det & (lowt_act == dps_pkg::DPS_ACT_ALARM),
                           ovt_det & (ovt_act == dps_pkg::DPS_ACT_ALARM),
                           motor_overload_condition_i & ol_cont};
  wire tq_status = ovt_det | lowt_det;
  wire rly1_next = fn_is_torque(relay_reg[4:0]) & tq_status;
  wire rly2_next = fn_is_torque(relay_reg[dps_pkg::RLY2_LSB +: 5]) & tq_status;
  wire avr_next = ~cfg_reg[dps_pkg::CFG_AVR_DIS];

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  wire [31:0] stat_word = {18'h00000, lowt_det, ovt_det, alarm_reg, 1'b0, fault_reg};
  wire [31:0] rd_word = sel_cfg ? {22'h000000, cfg_reg} :
                        sel_ovt ? {9'h000, ovt_reg} :
                        sel_lowt ? {9'h000, lowt_reg} :
                        sel_relay ? {19'h00000, relay_reg} :
                        sel_stat ? stat_word : 32'h00000000;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_reg <= dps_pkg::CFG_RST;
      ovt_reg <= dps_pkg::TQ_RST;
      lowt_reg <= dps_pkg::TQ_RST;
      relay_reg <= dps_pkg::RELAY_RST;
      prdata_reg <= '0;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      cfg_reg <= cfg_next;
      ovt_reg <= ovt_next;
      lowt_reg <= lowt_next;
      relay_reg <= relay_next;
      pready_reg <= acc & ~pready_reg;
      prdata_reg <= (acc && !pready_reg && !pwrite_i) ? rd_word : 32'h00000000;
      pslverr_reg <= acc & ~pready_reg & ~mapped;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_req_d_reg <= 1'b0;
      fault_reg <= '0;
      alarm_reg <= '0;
      coast_reg <= 1'b0;
      decel_reg <= 1'b0;
      contact_reg <= 1'b0;
    end else begin
      rst_req_d_reg <= rst_req_s;
      fault_reg <= fault_next;
      alarm_reg <= alarm_next;
      coast_reg <= coast_next;
      decel_reg <= decel_next;
      contact_reg <= contact_next;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      avr_reg <= 1'b1;
      rly1_reg <= 1'b0;
      rly2_reg <= 1'b0;
    end else begin
      avr_reg <= avr_next;
      rly1_reg <= rly1_next;
      rly2_reg <= rly2_next;
    end
  end

  assign prdata_o = prdata_reg;
  assign pready_o = pready_reg;
  assign pslverr_o = pslverr_reg;
  assign coast_stop_o = coast_reg;
  assign decel_stop_o = decel_reg;
  assign fault_contact_o = contact_reg;
  assign output_voltage_regulation_o = avr_reg;
  assign relay_output_one_o = rly1_reg;
  assign relay_output_two_o = rly2_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_ol_stop_trip: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    motor_overload_condition_i && !ol_cont |=> fault_reg[dps_pkg::F_OL] && coast_stop_o)
    else $error("overload in stop response did not trip");
  a_ol_cont_alarm: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ol_cont |=> alarm_reg[0] == $past(motor_overload_condition_i) && !fault_reg[dps_pkg::F_OL] ||
    $past(fault_reg[dps_pkg::F_OL]))
    else $error("overload alarm does not follow the condition");
  a_avr_follow: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ##1 output_voltage_regulation_o == !$past(cfg_reg[dps_pkg::CFG_AVR_DIS]))
    else $error("voltage regulation output wrong");
  a_ipl_trip: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ipl_en && ipl_s && out_current_pct_i >= dps_pkg::IPL_MIN_PCT |=> fault_contact_o && coast_stop_o)
    else $error("input phase loss did not trip");
  a_ipl_low_cur: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    out_current_pct_i < dps_pkg::IPL_MIN_PCT && !fault_reg[dps_pkg::F_IPL] |=> !fault_reg[dps_pkg::F_IPL])
    else $error("input phase loss detected at low current");
  a_opl_low_cur: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    out_current_pct_i < dps_pkg::OPL_MIN_PCT && !fault_reg[dps_pkg::F_OPL] |=> !fault_reg[dps_pkg::F_OPL])
    else $error("output phase loss detected at low current");
  a_gf_trip: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    gf_en && leakage_pct_i > dps_pkg::GF_LIM_PCT |=> coast_stop_o && fault_contact_o)
    else $error("earth leakage did not coast and trip");
  a_fault_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    fault_reg != '0 && !fault_clr |=> (fault_reg & $past(fault_reg)) == $past(fault_reg))
    else $error("latched fault dropped without reset");
  a_ext_cont: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ext_act == dps_pkg::DPS_EXT_CONT && !fault_reg[dps_pkg::F_EXT] |=> !fault_reg[dps_pkg::F_EXT])
    else $error("continue response latched an external fault");
  a_relay_torque: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    fn_is_torque(relay_reg[4:0]) && tq_status |=> relay_output_one_o)
    else $error("relay one missed torque detection");
endmodule // dps_top

// ==== src/dps_torque_det.sv ====
// torque excursion qualifier: above or below a level for a time
// assumes value and level share one percent scale, same clock
`timescale 1ns/1ns
module dps_torque_det #(
  parameter bit OVER = 1'b1,
  parameter int TICK_CYC = dps_pkg::TICK_CYC_DEF
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  // qualification
  input wire logic arm_i,
  input wire logic [9:0] value_i,
  input wire logic [8:0] level_i,
  input wire logic [6:0] time_i,
  // result
  output logic detect_o
);
  logic [24:0] cyc_reg;
  logic [6:0] tick_reg;
  logic detect_reg;
  wire excursion = OVER ? (value_i > {1'b0, level_i}) : (value_i < {1'b0, level_i});
  wire qual = arm_i & excursion;
  wire tick_done = (cyc_reg == 25'(TICK_CYC - 1));
  wire tick_sat = (tick_reg == dps_pkg::TIME_MAX);
  // any return across the level restarts both counters
  wire [24:0] cyc_next = (!qual || tick_done) ? 25'h0000000 : cyc_reg + 25'h0000001;
  wire [6:0] tick_next = !qual ? 7'h00 : ((tick_done && !tick_sat) ? tick_reg + 7'h01 : tick_reg);
  wire detect_next = qual & (tick_reg >= time_i);
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cyc_reg <= '0;
      tick_reg <= '0;
      detect_reg <= 1'b0;
    end else begin
      cyc_reg <= cyc_next;
      tick_reg <= tick_next;
      detect_reg <= detect_next;
    end
  end
  assign detect_o = detect_reg;

  a_det_restart: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !qual |=> !detect_o && tick_reg == 7'h00)
    else $error("detector did not restart after the excursion ended");
  a_det_zero_time: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    qual && time_i == 7'h00 |=> detect_o)
    else $error("zero qualifying time did not detect at once");
  a_det_needs_time: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(detect_o) |-> $past(tick_reg) >= $past(time_i))
    else $error("detection before the qualifying time");
endmodule // dps_torque_det

// ==== verification/dps_power_model.sv ====
// power stage and measurement model facing the supervisor
// assumes the bench calls meas, pins and run between clock edges
`timescale 1ns/1ns
module dps_power_model (
  // clock
  input wire logic clk_i,
  // stop requests
  input wire logic coast_stop_i,
  input wire logic decel_stop_i,
  // drive state and measurements
  output logic running_o,
  output logic at_set_freq_o,
  output logic overload_o,
  output logic [9:0] current_o,
  output logic [9:0] torque_o,
  output logic [9:0] leakage_o,
  // fault pins: in loss, out loss, external, reset
  output logic [3:0] pins_o
);
  logic run_cmd;
  initial begin
    run_cmd = 1'b1;
    {at_set_freq_o, overload_o, current_o, torque_o, leakage_o, pins_o} = '0;
  end
  // a stop request takes the drive out of run, as the real stage would
  always @(posedge clk_i) begin
    running_o <= run_cmd & ~coast_stop_i & ~decel_stop_i;
  end
  task automatic meas(input logic sf, input logic ol, input logic [9:0] c, input logic [9:0] t, input logic [9:0] l);
    @(posedge clk_i);
    at_set_freq_o <= sf;
    overload_o <= ol;
    current_o <= c;
    torque_o <= t;
    leakage_o <= l;
  endtask
  task automatic pins(input logic [3:0] p);
    @(posedge clk_i);
    pins_o <= p;
  endtask
  task automatic run(input logic r);
    @(posedge clk_i);
    run_cmd <= r;
  endtask
endmodule // dps_power_model

// ==== verification/tb_top.sv ====
// self-checking bench for the drive protection supervisor
// assumes the power model drives all measurement and pin inputs
`timescale 1ns/1ns
module tb_top;
  logic clk_i;
  logic rst_n_i;
  logic psel, penable, pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata_o;
  logic pready_o, pslverr_o, running, sf, ol, coast, decel, contact, output_voltage_regulation, rly1, rly2;
  logic [9:0] cur, tq, leak;
  logic [3:0] pins;
  int mismatches = 0;
  int compares = 0;
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  // short tick keeps torque timing to a few cycles
  dps_top #(.TICK_CYC(4)) dps_top_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .running_i(running), .at_set_freq_i(sf), .motor_overload_condition_i(ol),
    .out_current_pct_i(cur), .motor_torque_pct_i(tq), .leakage_pct_i(leak), .in_phase_loss_i(pins[0]),
    .out_phase_loss_i(pins[1]), .ext_fault_i(pins[2]), .fault_reset_i(pins[3]), .coast_stop_o(coast),
    .decel_stop_o(decel), .fault_contact_o(contact), .output_voltage_regulation_o(output_voltage_regulation),
    .relay_output_one_o(rly1), .relay_output_two_o(rly2));
  dps_power_model pm_i (.clk_i(clk_i), .coast_stop_i(coast), .decel_stop_i(decel), .running_o(running),
    .at_set_freq_o(sf), .overload_o(ol), .current_o(cur), .torque_o(tq), .leakage_o(leak), .pins_o(pins));
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      mismatches++;
      $display("BAD %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    @(posedge clk_i);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    do @(posedge clk_i); while (pready_o !== 1'b1);
    r = prdata_o;
    e = pslverr_o;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd(input string n, input logic [7:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(n, r, x);
  endtask
  task automatic outs(input logic [4:0] x); // contact, coast, decel, relay one, relay two
    repeat (5) @(posedge clk_i);
    chk("outputs", {contact, coast, decel, rly1, rly2}, x);
  endtask
  task automatic t_reset;
    logic [31:0] r;
    logic e;
    chk("avr", output_voltage_regulation, 1'b1);
    rd("cfg", dps_pkg::CFG_OFS, 32'h0);
    apb(1'b0, 8'h18, 32'h0, r, e);
    chk("unmapped err", e, 1'b1);
    wr(dps_pkg::STAT_OFS, 32'hFFFF);
    rd("status ro", dps_pkg::STAT_OFS, 32'h0);
    wr(dps_pkg::CFG_OFS, 32'h2);
    outs(5'h00);
    chk("avr off", output_voltage_regulation, 1'b0);
    wr(dps_pkg::CFG_OFS, 32'h0);
  endtask
  task automatic t_trip(input logic [31:0] cfg, input logic [3:0] p, input logic [9:0] clo, input logic [9:0] chi,
                        input logic [9:0] llo, input logic [9:0] lhi, input logic [31:0] st);
    wr(dps_pkg::CFG_OFS, cfg);
    pm_i.meas(1'b0, 1'b0, clo, 10'h0, llo);
    pm_i.pins(p);
    outs(5'h00);
    pm_i.meas(1'b0, 1'b0, chi, 10'h0, lhi);
    outs(5'h18);
    pm_i.pins(4'h0);
    pm_i.meas(1'b0, 1'b0, 10'h0, 10'h0, 10'h0);
    rd("latched", dps_pkg::STAT_OFS, st);
    wr(dps_pkg::CTRL_OFS, 32'h1);
    outs(5'h00);
  endtask
  task automatic t_ext;
    for (int a = 0; a < 3; a++) begin
      wr(dps_pkg::CFG_OFS, 32'(a) << 6);
      pm_i.pins(4'h4);
      outs({a != 2, a == 1, a == 0, 2'b00});
      pm_i.pins(4'h8);
      pm_i.pins(4'h0);
      outs(5'h00);
    end
    wr(dps_pkg::CFG_OFS, 32'h60);
    pm_i.run(1'b0);
    pm_i.pins(4'h4);
    outs(5'h00);
    pm_i.run(1'b1);
    outs(5'h18);
    pm_i.pins(4'h0);
    wr(dps_pkg::CTRL_OFS, 32'h1);
  endtask
  task automatic t_ovl;
    wr(dps_pkg::CFG_OFS, 32'h0);
    pm_i.meas(1'b0, 1'b1, 10'h0, 10'h0, 10'h0);
    outs(5'h18);
    pm_i.meas(1'b0, 1'b0, 10'h0, 10'h0, 10'h0);
    rd("overload held", dps_pkg::STAT_OFS, 32'h1);
    wr(dps_pkg::CTRL_OFS, 32'h1);
    wr(dps_pkg::CFG_OFS, 32'h1);
    pm_i.meas(1'b0, 1'b1, 10'h0, 10'h0, 10'h0);
    outs(5'h00);
    rd("overload alarm", dps_pkg::STAT_OFS, 32'h100);
    pm_i.meas(1'b0, 1'b0, 10'h0, 10'h0, 10'h0);
    rd("alarm gone", dps_pkg::STAT_OFS, 32'h0);
  endtask
  task automatic t_torque;
    wr(dps_pkg::CFG_OFS, 32'h0);
    wr(dps_pkg::RELAY_OFS, 32'h190C);
    wr(dps_pkg::OVT_OFS, 32'h20646);
    pm_i.meas(1'b0, 1'b0, 10'd101, 10'h0, 10'h0);
    repeat (4) @(posedge clk_i);
    pm_i.meas(1'b0, 1'b0, 10'd100, 10'h0, 10'h0);
    pm_i.meas(1'b0, 1'b0, 10'd101, 10'h0, 10'h0);
    outs(5'h00);
    // relays lag detection by one flop
    @(posedge clk_i);
    outs(5'h03);
    rd("ovt alarm", dps_pkg::STAT_OFS, 32'h1200);
    pm_i.meas(1'b0, 1'b0, 10'd100, 10'h0, 10'h0);
    outs(5'h00);
    wr(dps_pkg::OVT_OFS, 32'h20642);
    pm_i.meas(1'b0, 1'b0, 10'd101, 10'h0, 10'h0);
    // qualify 2 ticks, then the fault latch, then a settled sample
    repeat (11) @(posedge clk_i);
    chk("ovt decel", {contact, coast, decel}, 3'b101);
    pm_i.meas(1'b1, 1'b0, 10'd50, 10'h0, 10'h0);
    wr(dps_pkg::OVT_OFS, 32'h0);
    wr(dps_pkg::CTRL_OFS, 32'h1);
    wr(dps_pkg::LOWT_OFS, 32'h149);
    pm_i.meas(1'b0, 1'b0, 10'd10, 10'h0, 10'h0);
    outs(5'h00);
    pm_i.meas(1'b1, 1'b0, 10'd10, 10'h0, 10'h0);
    outs(5'h1B);
    pm_i.meas(1'b0, 1'b0, 10'd50, 10'h0, 10'h0);
    wr(dps_pkg::LOWT_OFS, 32'h0);
    wr(dps_pkg::CTRL_OFS, 32'h1);
    wr(dps_pkg::CFG_OFS, 32'h200);
    wr(dps_pkg::OVT_OFS, 32'h646);
    pm_i.meas(1'b0, 1'b0, 10'd150, 10'd50, 10'h0);
    outs(5'h00);
    pm_i.meas(1'b0, 1'b0, 10'd50, 10'd150, 10'h0);
    outs(5'h03);
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    rst_n_i <= 1'b0;
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    paddr <= 8'h00;
    pwdata <= 32'h00000000;
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    t_reset();
    t_trip(32'h4, 4'h1, 10'd29, 10'd30, 10'h0, 10'h0, 32'h2);
    t_trip(32'h8, 4'h2, 10'd9, 10'd10, 10'h0, 10'h0, 32'h4);
    t_trip(32'h10, 4'h0, 10'd50, 10'd50, 10'd50, 10'd51, 32'h8);
    t_ext();
    t_ovl();
    t_torque();
    conclude();
  end
  // the whole run needs a few hundred cycles
  initial begin
    #200000;
    mismatches++;
    conclude();
  end
endmodule // tb_top
